/* src/t1_rx_cfg_loopback_regs.sv */
// Purpose: per-channel receive configuration and loopback register bank
// Assumes: classic wishbone, 32-bit data, byte address = 4 * register index
// Notes: eight channel copies; control outputs lag a register write by one cycle
//
// Contract
// [RULE_01] attenuator bypassed when off, used when on
// [RULE_02] depth code selects 128, 64, 32 bits
// [RULE_03] corner bit selects 5 Hz or 1.26 Hz
// [RULE_04] widen near pointer limits when enabled
// [RULE_05] widened stops attenuating; limit off keeps normal
// [RULE_06] power-off bit powers down receive path
// [RULE_07] line code bit picks b8zs or ami
// [RULE_08] equalizer bit off short haul, on long
// [RULE_09] threshold code: -4 dB, 2 dB steps, -48
// [RULE_10] threshold code ignored in short haul
// [RULE_11] declare loss after n silent low intervals
// [RULE_12] slicer code gives 40 to 70 percent
// [RULE_13] peak window code gives 32 to 256
// [RULE_14] gain 0 or 22 dB, reserved codes unused
// [RULE_15] first local digital loop enable bit
// [RULE_16] system local loop enable bit
// [RULE_17] system remote loop enable bit
// [RULE_18] line remote loop enable bit
// [RULE_19] analog loop enable bit
// [RULE_20] second local digital loop enable bit
// [RULE_21] eight channel copies spaced 0x100 apart
// [RULE_22] reserved bits read zero, ignore writes
`include "t1_rx_cfg_params.svh"
`default_nettype none
module t1_rx_cfg_loopback_regs #(
  parameter int CHANNELS = 8,
  parameter int LOS_INTERVALS = `LOS_INTERVALS_DEFAULT
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [12:2] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_rx_raw_data [CHANNELS],
  input wire logic i_rx_atten_data [CHANNELS],
  input wire logic [7:0] i_fifo_fill [CHANNELS],
  input wire logic i_bit_tick [CHANNELS],
  input wire logic i_rx_level_low [CHANNELS],
  input wire logic i_rx_transition [CHANNELS],
  output t1_rx_cfg_pkg::ch_ctrl_t o_ch_ctrl [CHANNELS],
  output logic o_rx_data [CHANNELS],
  output logic o_widened [CHANNELS],
  output logic o_los [CHANNELS]
);
  import t1_rx_cfg_pkg::*;

  localparam int CW = $clog2(LOS_INTERVALS + 1);

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // elastic buffer depth in bits
  function automatic logic [7:0] depth_of(input logic [1:0] code);
    logic [7:0] d;
    d = 8'h20;
    if (code == 2'h0) begin
      d = 8'h80; // [RULE_02]
    end else if (code == 2'h1) begin
      d = 8'h40;
    end
    return d;
  endfunction

  // near-limit window width, wider for deeper buffers
  function automatic logic [7:0] margin_of(input logic [1:0] code);
    logic [7:0] m;
    m = 8'h02;
    if (code == 2'h0) begin
      m = 8'h04; // [RULE_04]
    end else if (code == 2'h1) begin
      m = 8'h03;
    end
    return m;
  endfunction

  // loss threshold magnitude in dB below nominal
  function automatic logic [5:0] q_db_of(input logic [4:0] code);
    logic [5:0] q;
    q = 6'h30; // [RULE_09]
    if (code < `Q_CODE_MAX) begin
      q = 6'h04 + {code, 1'b0};
    end
    return q;
  endfunction

  // slicer threshold in percent of peak
  function automatic logic [6:0] slice_of(input logic [1:0] code);
    logic [6:0] p;
    case (code) // [RULE_12]
      2'h0: p = 7'h28;
      2'h1: p = 7'h32;
      2'h2: p = 7'h3C;
      default: p = 7'h46;
    endcase
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] jit_reg [CHANNELS]; // jitter attenuator setup
  logic [7:0] path_reg [CHANNELS]; // power and line code
  logic [7:0] level_reg [CHANNELS]; // equalizer and loss threshold
  logic [7:0] slicer_reg [CHANNELS]; // slicer, peak window, gain
  logic [7:0] loop_reg [CHANNELS]; // loopback enables
  logic los_reg [CHANNELS]; // loss of signal state
  logic widened_reg [CHANNELS]; // attenuator in widened mode

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  logic ack_reg; // answer strobe
  logic [7:0] rd_reg; // latched read byte
  logic [7:0] rd_next; // read byte for the current address
  logic [2:0] chan; // channel from the index
  logic [7:0] offs; // register index within a channel
  logic chan_ok; // channel exists
  logic wr_fire; // write takes effect on this edge

  // the channel is the top three bits of the eleven-bit register index
  assign chan = i_wb_adr[12:10]; // [RULE_21]
  assign offs = i_wb_adr[9:2] == 8'h00 ? 8'h00 : i_wb_adr[9:2];
  assign chan_ok = (32'(chan) < CHANNELS);
  assign wr_fire = i_wb_cyc && i_wb_stb && i_wb_we && ack_reg && i_wb_sel[0] && chan_ok;
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = {24'h000000, rd_reg}; // [RULE_22]

  // read decode; unmapped addresses read zero
  always_comb begin
    rd_next = 8'h00;
    if (!chan_ok) begin
      rd_next = 8'h00;
    end else if (offs == `IDX_JITTER) begin
      rd_next = jit_reg[chan];
    end else if (offs == `IDX_PATH) begin
      rd_next = path_reg[chan];
    end else if (offs == `IDX_LEVEL) begin
      rd_next = level_reg[chan];
    end else if (offs == `IDX_SLICER) begin
      rd_next = slicer_reg[chan];
    end else if (offs == `IDX_LOOP) begin
      rd_next = loop_reg[chan];
    end else if (offs == `IDX_STATUS) begin
      rd_next = {6'h00, widened_reg[chan], los_reg[chan]};
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_reg <= 1'b0;
      rd_reg <= 8'h00;
    end else begin
      ack_reg <= i_wb_cyc && i_wb_stb && !ack_reg;
      if (i_wb_cyc && i_wb_stb && !ack_reg) begin
        rd_reg <= i_wb_we ? 8'h00 : rd_next;
      end
    end
  end

  // register writes land on the edge where the master samples ack, one cycle after the edge that raises it
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        jit_reg[c] <= `RST_JITTER;
        path_reg[c] <= `RST_PATH;
        level_reg[c] <= `RST_LEVEL;
        slicer_reg[c] <= `RST_SLICER;
        loop_reg[c] <= `RST_LOOP;
      end
    end else if (wr_fire) begin
      if (offs == `IDX_JITTER) begin
        jit_reg[chan] <= i_wb_dat[7:0] & `MASK_JITTER; // [RULE_22]
      end else if (offs == `IDX_PATH) begin
        path_reg[chan] <= i_wb_dat[7:0] & `MASK_PATH;
      end else if (offs == `IDX_LEVEL) begin
        level_reg[chan] <= i_wb_dat[7:0] & `MASK_LEVEL;
      end else if (offs == `IDX_SLICER) begin
        slicer_reg[chan] <= i_wb_dat[7:0] & `MASK_SLICER;
      end else if (offs == `IDX_LOOP) begin
        loop_reg[chan] <= i_wb_dat[7:0] & `MASK_LOOP;
      end
    end
  end

  a_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_reserved_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000) // RULE_22
    else $error("upper read bits not zero");
  c_write_done: cover property (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack);
  // a read answered with data
  c_read_done: cover property (i_wb_cyc && i_wb_stb && !i_wb_we && o_wb_ack);

  ////////////////////////////////////////////////////////////////////////////
  // per-channel datapath controls

  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    logic lvl_meta, lvl_sync; // level comparator synchroniser
    logic trn_meta, trn_sync; // transition detector synchroniser
    logic [CW-1:0] cnt_reg; // silent intervals counted
    logic [7:0] depth; // buffer depth in bits
    logic [7:0] margin; // near-limit window
    logic near; // pointers inside the window
    logic powered; // receive path on
    logic long_haul; // equalizer enabled
    ch_ctrl_t ctrl_next; // decoded controls

    assign powered = !path_reg[g][`B_PATH_OFF]; // [RULE_06]
    assign long_haul = level_reg[g][`B_LVL_EQ]; // [RULE_08]
    assign depth = depth_of(jit_reg[g][`B_JIT_DP +: 2]);
    assign margin = margin_of(jit_reg[g][`B_JIT_DP +: 2]);
    assign near = (i_fifo_fill[g] <= margin) || (i_fifo_fill[g] >= depth - margin); // [RULE_04]

    // two-stage synchronisers for the analog level and transition pins
    always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
        lvl_meta <= 1'b0;
        lvl_sync <= 1'b0;
        trn_meta <= 1'b0;
        trn_sync <= 1'b0;
      end else begin
        lvl_meta <= i_rx_level_low[g];
        lvl_sync <= lvl_meta;
        trn_meta <= i_rx_transition[g];
        trn_sync <= trn_meta;
      end
    end

    // decode the register codes into usable controls
    always_comb begin
      ctrl_next.rx_powered = powered;
      ctrl_next.jitter_atten_on = jit_reg[g][`B_JIT_ON];
      ctrl_next.atten_depth_bits = depth; // [RULE_02]
      ctrl_next.corner_low = jit_reg[g][`B_JIT_BW]; // [RULE_03]
      ctrl_next.b8zs_decode = !path_reg[g][`B_PATH_CODE]; // [RULE_07]
      ctrl_next.equalizer_on = long_haul;
      // short haul has no programmable threshold [RULE_10]
      ctrl_next.los_q_db = long_haul ? q_db_of(level_reg[g][`B_LVL_Q +: 5]) : 6'h00;
      ctrl_next.slicer_pct = slice_of(slicer_reg[g][`B_SLC_SLICE +: 2]);
      ctrl_next.peak_window_bits = 9'h020 << slicer_reg[g][`B_SLC_WIN +: 2]; // [RULE_13]
      // reserved gain codes give no gain [RULE_14]
      ctrl_next.monitor_gain_db = slicer_reg[g][`B_SLC_GAIN +: 2] == 2'h1 ? 5'h16 : 5'h00;
      ctrl_next.loops.local_digital_loop_one = loop_reg[g][`B_LP_DIG1]; // [RULE_15]
      ctrl_next.loops.system_local_loop = loop_reg[g][`B_LP_SLOC]; // [RULE_16]
      ctrl_next.loops.system_remote_loop = loop_reg[g][`B_LP_SREM]; // [RULE_17]
      ctrl_next.loops.line_remote_loop = loop_reg[g][`B_LP_LREM]; // [RULE_18]
      ctrl_next.loops.analog_loop = loop_reg[g][`B_LP_ANALOG]; // [RULE_19]
      ctrl_next.loops.local_digital_loop_two = loop_reg[g][`B_LP_DIG2]; // [RULE_20]
    end

    // registered control outputs
    always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
        o_ch_ctrl[g] <= '0;
      end else begin
        o_ch_ctrl[g] <= ctrl_next;
      end
    end

    // data route: through the attenuator or around it, quiet when powered off
    always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
        o_rx_data[g] <= 1'b0;
      end else if (!powered) begin
        o_rx_data[g] <= 1'b0; // [RULE_06]
      end else if (jit_reg[g][`B_JIT_ON]) begin
        o_rx_data[g] <= i_rx_atten_data[g]; // [RULE_01]
      end else begin
        o_rx_data[g] <= i_rx_raw_data[g]; // [RULE_01]
      end
    end

    // widened mode only while enabled and pointers near a limit
    always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
        widened_reg[g] <= 1'b0;
      end else begin
        widened_reg[g] <= jit_reg[g][`B_JIT_LIMIT] && jit_reg[g][`B_JIT_ON]
          && powered && near; // [RULE_05]
      end
    end
    assign o_widened[g] = widened_reg[g];

    // count silent low-level intervals; declare after the set number
    always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
        cnt_reg <= '0;
        los_reg[g] <= 1'b0;
      end else if (!powered) begin
        cnt_reg <= '0;
        los_reg[g] <= 1'b0;
      end else if (i_bit_tick[g]) begin
        if (lvl_sync && !trn_sync) begin
          if (32'(cnt_reg) < LOS_INTERVALS) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
          los_reg[g] <= (32'(cnt_reg) >= LOS_INTERVALS - 1); // [RULE_11]
        end else begin
          cnt_reg <= '0;
          los_reg[g] <= 1'b0;
        end
      end
    end
    assign o_los[g] = los_reg[g];

    a_bypass_route: assert property ( // RULE_01
      powered && !jit_reg[g][`B_JIT_ON] |=> o_rx_data[g] == $past(i_rx_raw_data[g]))
      else $error("raw data not passed with attenuator off");
    a_atten_route: assert property ( // RULE_01
      powered && jit_reg[g][`B_JIT_ON] |=> o_rx_data[g] == $past(i_rx_atten_data[g]))
      else $error("attenuated data not passed with attenuator on");
    a_depth_deep: assert property ( // RULE_02
      jit_reg[g][`B_JIT_DP +: 2] == 2'h0 |=> o_ch_ctrl[g].atten_depth_bits == 8'h80)
      else $error("depth code zero not 128 bits");
    a_widen_limit: assert property ( // RULE_05
      !jit_reg[g][`B_JIT_LIMIT] |=> !o_widened[g])
      else $error("widened without limit bit");
    a_power_off: assert property ( // RULE_06
      !powered ##1 !powered |-> !o_rx_data[g] && !o_los[g])
      else $error("powered-off path still active");
    a_short_haul_q: assert property ( // RULE_10
      !long_haul |=> o_ch_ctrl[g].los_q_db == 6'h00)
      else $error("threshold used in short haul");
    a_los_count: assert property ( // RULE_11
      $rose(o_los[g]) |-> 32'($past(cnt_reg)) == LOS_INTERVALS - 1)
      else $error("loss declared at wrong count");
    a_gain_code: assert property ( // RULE_14
      slicer_reg[g][1:0] == 2'h1 |=> o_ch_ctrl[g].monitor_gain_db == 5'h16)
      else $error("monitor gain code one not 22 dB");
    c_widened: cover property (o_widened[g]);
    c_los: cover property ($rose(o_los[g]));

    // decoded fields follow their register bits one cycle later; the first
    // check waits one cycle so the reset image of the outputs is not judged
    a_widen_near: assert property ( // RULE_04
      jit_reg[g][`B_JIT_LIMIT] && jit_reg[g][`B_JIT_ON] && powered && near |=> o_widened[g])
      else $error("not widened near a pointer limit");
    a_q_saturate: assert property ( // RULE_09
      long_haul && level_reg[g][`B_LVL_Q +: 5] >= `Q_CODE_MAX |=> o_ch_ctrl[g].los_q_db == 6'h30)
      else $error("threshold code above range not at 48 dB");
    a_corner_code: assert property ( // RULE_03
      1'b1 |=> o_ch_ctrl[g].corner_low == $past(jit_reg[g][`B_JIT_BW]))
      else $error("corner select not following its bit");
    a_line_code: assert property ( // RULE_07
      1'b1 |=> o_ch_ctrl[g].b8zs_decode == !$past(path_reg[g][`B_PATH_CODE]))
      else $error("decoder select not following its bit");
    a_window_len: assert property ( // RULE_13
      slicer_reg[g][`B_SLC_WIN +: 2] == 2'h3 |=> o_ch_ctrl[g].peak_window_bits == 9'h100)
      else $error("window code three not 256 bits");
    a_loop_map: assert property ( // RULE_18
      1'b1 |=> o_ch_ctrl[g].loops.line_remote_loop == $past(loop_reg[g][`B_LP_LREM]))
      else $error("line remote loop not following its bit");
    // stored images never hold a reserved bit, whatever software wrote
    a_reserved_store: assert property ( // RULE_22
      ((jit_reg[g] & ~`MASK_JITTER) | (path_reg[g] & ~`MASK_PATH)
        | (level_reg[g] & ~`MASK_LEVEL) | (slicer_reg[g] & ~`MASK_SLICER)
        | (loop_reg[g] & ~`MASK_LOOP)) == 8'h00)
      else $error("reserved bit stored in a register");
  end
endmodule
`default_nettype wire

/* src/t1_rx_cfg_params.svh */
// Purpose: constants for the t1 receive configuration and loopback bank
// Assumes: included by bare name from the testbench and the design file
// Notes: offsets are register indices; the byte address is four times the index
`ifndef T1_RX_CFG_PARAMS_SVH
`define T1_RX_CFG_PARAMS_SVH
// register indices within one channel (channel n adds n * 0x100)
`define IDX_JITTER 8'h27
`define IDX_PATH 8'h28
`define IDX_LEVEL 8'h29
`define IDX_SLICER 8'h2A
`define IDX_LOOP 8'h2B
`define IDX_STATUS 8'h30
// writable bit masks, reserved bits stay zero
`define MASK_JITTER 8'h3F
`define MASK_PATH 8'h11
`define MASK_LEVEL 8'h5F
`define MASK_SLICER 8'h3F
`define MASK_LOOP 8'h77
// reset values
`define RST_JITTER 8'h00
`define RST_PATH 8'h00
`define RST_LEVEL 8'h15
`define RST_SLICER 8'h18
`define RST_LOOP 8'h00
// field positions
`define B_JIT_BW 0
`define B_JIT_DP 1
`define B_JIT_ON 3
`define B_JIT_LIMIT 4
`define B_PATH_CODE 0
`define B_PATH_OFF 4
`define B_LVL_Q 0
`define B_LVL_EQ 6
`define B_SLC_GAIN 0
`define B_SLC_WIN 2
`define B_SLC_SLICE 4
`define B_LP_DIG2 0
`define B_LP_ANALOG 1
`define B_LP_LREM 2
`define B_LP_SREM 4
`define B_LP_SLOC 5
`define B_LP_DIG1 6
// loss of signal: pulse intervals without transitions before declaring
`define LOS_INTERVALS_DEFAULT 175
// lowest threshold code that saturates; codes below it have their own step
`define Q_CODE_MAX 5'h16
`endif

/* src/t1_rx_cfg_pkg.sv */
// Purpose: types shared by the receive configuration bank and its users
// Assumes: nothing beyond standard systemverilog
// Notes: control fields are decoded values, not raw register codes
`default_nettype none
package t1_rx_cfg_pkg;
  // six loopback enables of one channel
  typedef struct packed {
    logic local_digital_loop_one;
    logic system_local_loop;
    logic system_remote_loop;
    logic line_remote_loop;
    logic analog_loop;
    logic local_digital_loop_two;
  } loopback_t;
  // decoded receive controls of one channel
  typedef struct packed {
    logic rx_powered;
    logic jitter_atten_on;
    logic [7:0] atten_depth_bits;
    logic corner_low;
    logic b8zs_decode;
    logic equalizer_on;
    logic [5:0] los_q_db;
    logic [6:0] slicer_pct;
    logic [8:0] peak_window_bits;
    logic [4:0] monitor_gain_db;
    loopback_t loops;
  } ch_ctrl_t;
endpackage
`default_nettype wire

/* verif/t1_line_model.sv */
// Purpose: line-side stand-in that feeds the receive datapath of every channel
// Assumes: one pulse interval every four clocks; the bench sets fill and silence
// Notes: raw and attenuated streams differ so the selected path is visible
`default_nettype none
module t1_line_model #(
  parameter int CHANNELS = 8
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_silent [CHANNELS],
  input wire logic [7:0] i_fill [CHANNELS],
  output logic o_raw [CHANNELS],
  output logic o_atten [CHANNELS],
  output logic [7:0] o_fill [CHANNELS],
  output logic o_tick [CHANNELS],
  output logic o_level_low [CHANNELS],
  output logic o_transition [CHANNELS]
);
  logic [1:0] phase_reg; // position within one pulse interval
  ////////////////////////////////////////////////////////////////////////////////
  // line bit phase, one interval is four clocks
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // streams per channel; a silent line is low with no transitions
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      o_raw[c] = phase_reg[0];
      o_atten[c] = phase_reg[1] ^ phase_reg[0];
      o_fill[c] = i_fill[c];
      o_tick[c] = (phase_reg == 2'h3);
      o_level_low[c] = i_silent[c];
      o_transition[c] = !i_silent[c];
    end
  end
endmodule
`default_nettype wire

/* verif/t1_rx_cfg_loopback_regs_tb.sv */
// Purpose: self-checking bench for the receive configuration and loopback bank
// Assumes: classic wishbone, one register per word, short loss count of 4
// Notes: decoded controls are predicted here from register images of channel 0
`include "t1_rx_cfg_params.svh"
`default_nettype none
module t1_rx_cfg_loopback_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import t1_rx_cfg_pkg::*;
  localparam int CH = 8;
  localparam int LIMIT = 20000; // cycle ceiling, tests need under 1000
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic [12:2] wb_adr = 11'h000;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic raw [CH];
  logic att [CH];
  logic [7:0] fill [CH];
  logic tick [CH];
  logic low [CH];
  logic trans [CH];
  logic silent [CH] = '{default: 1'b0}; // bench-controlled line silence
  logic [7:0] fill_set [CH] = '{default: 8'h10}; // pointer separation
  ch_ctrl_t ctrl [CH];
  logic rx_data [CH];
  logic widened [CH];
  logic los [CH];
  logic prev_raw = 1'b0; // streams as the bank sampled them
  logic prev_att = 1'b0;
  logic [7:0] regs [5] = '{`IDX_JITTER, `IDX_PATH, `IDX_LEVEL, `IDX_SLICER, `IDX_LOOP};
  logic [7:0] masks [5] = '{8'h3F, 8'h11, 8'h5F, 8'h3F, 8'h77};
  logic [7:0] sh [5] = '{8'h00, 8'h00, 8'h15, 8'h18, 8'h00}; // channel 0 images
  logic [7:0] fills [5] = '{8'h02, 8'h03, 8'h10, 8'h1D, 8'h1E};
  logic wide_exp [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1}; // margin 2 at depth 32
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  t1_rx_cfg_loopback_regs #(.CHANNELS(CH), .LOS_INTERVALS(4)) i_t1_rx_cfg_loopback_regs (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat),
    .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .i_rx_raw_data(raw), .i_rx_atten_data(att),
    .i_fifo_fill(fill), .i_bit_tick(tick), .i_rx_level_low(low),
    .i_rx_transition(trans), .o_ch_ctrl(ctrl), .o_rx_data(rx_data),
    .o_widened(widened), .o_los(los));
  t1_line_model #(.CHANNELS(CH)) i_t1_line_model (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_silent(silent), .i_fill(fill_set),
    .o_raw(raw), .o_atten(att), .o_fill(fill), .o_tick(tick), .o_level_low(low),
    .o_transition(trans));
  ////////////////////////////////////////////////////////////////////////////////
  // clock, sampled streams and hang guard
  initial begin
    forever #12.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    prev_raw <= raw[0];
    prev_att <= att[0];
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // comparison, verdict and bus tasks
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one classic cycle held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [10:0] idx, input logic [7:0] wd,
                         output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge i_clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hF;
    wb_adr <= idx;
    wb_dat <= {24'h0, wd};
    do begin
      @(posedge i_clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat[7:0];
    check("bus ack", wb_ack, 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_sel <= 4'h0;
  endtask
  task automatic wr(input logic [10:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb_xfer(1'b1, idx, d, r);
  endtask
  task automatic rdchk(input string what, input logic [10:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    wb_xfer(1'b0, idx, 8'h00, r);
    check(what, r, exp);
  endtask
  // expected loopback enables from a loop register image
  function automatic loopback_t loops_of(input logic [7:0] lp);
    return {lp[6], lp[5], lp[4], lp[2], lp[1], lp[0]};
  endfunction
  // expected decoded controls from register images
  function automatic ch_ctrl_t decode(input logic [7:0] j, p, l, s, lp);
    ch_ctrl_t e;
    e.rx_powered = !p[4];
    e.jitter_atten_on = j[3];
    e.atten_depth_bits = j[2] ? 8'h20 : (j[1] ? 8'h40 : 8'h80);
    e.corner_low = j[0];
    e.b8zs_decode = !p[0];
    e.equalizer_on = l[6];
    e.los_q_db = !l[6] ? 6'h00 : (l[4:0] >= 5'h16 ? 6'h30 : 6'h04 + {l[4:0], 1'b0});
    e.slicer_pct = 7'h28 + 7'(s[5:4]) * 7'h0A;
    e.peak_window_bits = 9'h020 << s[3:2];
    e.monitor_gain_db = (s[1:0] == 2'h1) ? 5'h16 : 5'h00;
    e.loops = loops_of(lp);
    return e;
  endfunction
  // write a channel 0 register, read it back, compare the decoded controls
  task automatic set(input int k, input logic [7:0] d);
    wr({3'h0, regs[k]}, d);
    sh[k] = d & masks[k];
    rdchk("readback", {3'h0, regs[k]}, sh[k]);
    @(negedge i_clock);
    check("ctrl", ctrl[0], decode(sh[0], sh[1], sh[2], sh[3], sh[4]));
  endtask
  task automatic dpath(input int mode);
    repeat (8) begin
      @(negedge i_clock);
      check("rx data", rx_data[0], mode == 0 ? prev_raw : (mode == 1 ? prev_att : 1'b0));
    end
  endtask
  task automatic wait_los(input logic lv);
    int n;
    n = 0;
    while (los[0] !== lv && n < 60) begin
      @(negedge i_clock);
      n++;
    end
    check("los", los[0], lv);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      rdchk("reset value", {3'h0, regs[k]}, sh[k]);
    end
    check("ctrl reset", ctrl[0], decode(sh[0], sh[1], sh[2], sh[3], sh[4]));
    for (int k = 0; k < 5; k++) begin
      set(k, k == 3 ? 8'hFD : 8'hFF);
    end
    wr(11'h000, 8'hFF);
    rdchk("unmapped", 11'h000, 8'h00);
    for (int i = 0; i < 16; i++) begin
      set(0, 8'(i));
    end
    set(1, 8'h01);
    set(1, 8'h10);
    set(1, 8'h00);
    for (int i = 0; i < 32; i++) begin
      set(2, 8'h40 | 8'(i));
    end
    set(2, 8'h0A);
    for (logic [4:0] i = 5'h00; i < 5'h10; i++) begin
      set(3, {2'h0, i[3:0], 1'b0, i[0]});
    end
    for (int b = 0; b < 8; b++) begin
      set(4, 8'h01 << b);
    end
    for (int c = 1; c < CH; c++) begin
      wr({3'(c), `IDX_LOOP}, 8'h01 << (c - 1));
    end
    for (int c = 1; c < CH; c++) begin
      rdchk("channel loop", {3'(c), `IDX_LOOP}, (8'h01 << (c - 1)) & 8'h77);
      check("channel ctrl", ctrl[c].loops, loops_of((8'h01 << (c - 1)) & 8'h77));
    end
    rdchk("channel 0 kept", {3'h0, `IDX_LOOP}, sh[4]);
    set(0, 8'h00);
    dpath(0);
    set(0, 8'h08);
    dpath(1);
    set(1, 8'h10);
    dpath(2);
    set(1, 8'h00);
    set(0, 8'h1C);
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clock);
      fill_set[0] <= fills[i];
      repeat (3) @(negedge i_clock);
      check("widened", widened[0], wide_exp[i]);
    end
    rdchk("status wide", {3'h0, `IDX_STATUS}, 8'h02);
    set(0, 8'h0C);
    repeat (3) @(negedge i_clock);
    check("widened off", widened[0], 1'b0);
    @(posedge i_clock);
    fill_set[0] <= 8'h10;
    silent[0] <= 1'b1;
    repeat (8) @(negedge i_clock);
    check("los early", los[0], 1'b0);
    wait_los(1'b1);
    wr({3'h0, `IDX_STATUS}, 8'h00);
    rdchk("status los", {3'h0, `IDX_STATUS}, 8'h01);
    @(posedge i_clock);
    silent[0] <= 1'b0;
    wait_los(1'b0);
    @(posedge i_clock);
    silent[0] <= 1'b1;
    wait_los(1'b1);
    set(1, 8'h10);
    repeat (2) @(negedge i_clock);
    check("los off", los[0], 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
